//--- verilog/vatu_map.vh
// Function
// - accept 32-bit byte virtual addresses
// - top bit set selects shared system region
// - next bit picks program or control region
// - byte, word, longword and quadword sizes
// - memory requests are naturally aligned
// - split unaligned operands into aligned pieces
// - translate and protect 512-byte pages
// - low nine bits pass through unchanged
// - two top bits pick table, 21 index
// - enforce entry protection code per reference
// - frame number joined with byte offset
// - valid bit marks resident physical page
// - set modified flag on any write
// - translation buffer hit skips memory fetch, except a write to a clean page
// - length register bounds each region
// - system table fetched from contiguous physical memory
// - process tables live in system virtual space
// - buffered table-page mapping saves one fetch
// - device-space pages get same protection check
`ifndef VATU_MAP_VH
`define VATU_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define VATU_CTRL_OFS       8'h00
`define VATU_SYS_BASE_OFS   8'h04
`define VATU_SYS_LEN_OFS    8'h08
`define VATU_PROG_BASE_OFS  8'h0c
`define VATU_PROG_LEN_OFS   8'h10
`define VATU_CTL_BASE_OFS   8'h14
`define VATU_CTL_LEN_OFS    8'h18
`define VATU_STATUS_OFS     8'h1c
`define VATU_FAULT_VA_OFS   8'h20
`define VATU_REG_RESET      32'h0000_0000

// ****************************************************************
// page map entry layout
// ****************************************************************
`define VATU_PME_VALID      31
`define VATU_PME_PROT_HI    30
`define VATU_PME_PROT_LO    27
`define VATU_PME_MOD        26
`define VATU_PME_FRAME_HI   20
`define VATU_OFS_BITS       9
`define VATU_IDX_BITS       21

// ****************************************************************
// fault codes, sizes
// ****************************************************************
`define VATU_FLT_NONE       2'h0
`define VATU_FLT_ACCV       2'h1
`define VATU_FLT_TNV        2'h2
`define VATU_SZ_BYTE        2'h0
`define VATU_SZ_QUAD        2'h3
`define VATU_SYS_REGION     2'h2

`endif

//--- verilog/vatu_chunk.v
`timescale 1ns/100ps
`include "vatu_map.vh"
module vatu_chunk (
   // current address and bytes left
   input  wire [2:0] addr_lo,
   input  wire [3:0] remain,
   // largest aligned piece
   output reg  [1:0] size
);
   always @* begin
      if (remain >= 4'h8 && addr_lo == 3'h0) begin
         size = `VATU_SZ_QUAD;
      end else if (remain >= 4'h4 && addr_lo[1:0] == 2'h0) begin
         size = 2'h2;
      end else if (remain >= 4'h2 && addr_lo[0] == 1'b0) begin
         size = 2'h1;
      end else begin
         size = `VATU_SZ_BYTE;
      end
   end
endmodule // vatu_chunk

//--- verilog/vatu_tlb.v
`timescale 1ns/100ps
module vatu_tlb #(
   parameter ENTRIES = 8,
   parameter PTR_W   = 3
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // lookup
   input  wire [22:0] look_key,
   output reg         hit,
   output reg  [31:0] hit_pme,
   // fill or refresh, flush
   input  wire        fill_en,
   input  wire [22:0] fill_key,
   input  wire [31:0] fill_pme,
   input  wire        flush
);
   reg [22:0]        key_mem [0:ENTRIES-1];
   reg [31:0]        pme_mem [0:ENTRIES-1];
   reg [ENTRIES-1:0] used_reg;
   reg [PTR_W-1:0]   victim_reg;
   reg               same;
   reg [PTR_W-1:0]   same_idx;
   integer           i;

   always @* begin
      hit      = 1'b0;
      hit_pme  = 32'h0000_0000;
      same     = 1'b0;
      same_idx = {PTR_W{1'b0}};
      for (i = 0; i < ENTRIES; i = i + 1) begin
         if (used_reg[i] && key_mem[i] == look_key) begin
            hit     = 1'b1;
            hit_pme = pme_mem[i];
         end
         if (used_reg[i] && key_mem[i] == fill_key) begin
            same     = 1'b1;
            same_idx = i[PTR_W-1:0];
         end
      end
   end

   // refresh in place so a modified flag never lives twice
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         used_reg   <= {ENTRIES{1'b0}};
         victim_reg <= {PTR_W{1'b0}};
      end else if (flush) begin
         used_reg <= {ENTRIES{1'b0}};
      end else if (fill_en) begin
         if (same) begin
            pme_mem[same_idx] <= fill_pme;
         end else begin
            key_mem[victim_reg]  <= fill_key;
            pme_mem[victim_reg]  <= fill_pme;
            used_reg[victim_reg] <= 1'b1;
            victim_reg           <= victim_reg + {{(PTR_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // vatu_tlb

//--- verilog/vatu_top.v
`timescale 1ns/100ps
`include "vatu_map.vh"
module vatu_top #(
   parameter TLB_ENTRIES = 8,
   parameter TLB_PTR_W   = 3
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   // processor request
   input  wire        cpu_req,
   input  wire [31:0] cpu_vaddr,
   input  wire [3:0]  cpu_len,
   input  wire        cpu_write,
   input  wire [1:0]  cpu_mode,
   output reg         cpu_ready,
   output reg         cpu_done,
   output reg         cpu_fault,
   output reg  [1:0]  cpu_fault_code,
   // physical memory request
   output reg         mem_req,
   output reg  [29:0] mem_addr,
   output reg  [1:0]  mem_size,
   output reg         mem_write,
   output reg         mem_table,
   output reg  [31:0] mem_wdata,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata
);
   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] S_IDLE    = 3'h0;
   localparam [2:0] S_LOOK    = 3'h1;
   localparam [2:0] S_SYSLOOK = 3'h2;
   localparam [2:0] S_FSYS    = 3'h3;
   localparam [2:0] S_FPME    = 3'h4;
   localparam [2:0] S_CHECK   = 3'h5;
   localparam [2:0] S_MODW    = 3'h6;
   localparam [2:0] S_DATA    = 3'h7;

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [31:0] sys_base_reg;
   reg [31:0] sys_len_reg;
   reg [31:0] prog_base_reg;
   reg [31:0] prog_len_reg;
   reg [31:0] ctl_base_reg;
   reg [31:0] ctl_len_reg;
   reg [31:0] fault_va_reg;
   reg [1:0]  last_fault_reg;
   reg        flush_reg;
   reg        wr_pend_reg;
   reg [7:0]  wr_ofs_reg;

   reg [2:0]  state_reg;
   reg [31:0] va_reg;
   reg [3:0]  rem_reg;
   reg        wr_reg;
   reg [1:0]  mode_reg;
   reg [31:0] pme_reg;
   reg [29:0] pme_addr_reg;
   reg [31:0] ptva_reg;
   reg        fill_en_reg;
   reg [22:0] fill_key_reg;
   reg [31:0] fill_pme_reg;

   // ****************************************************************
   // address split and checks
   // ****************************************************************
   wire [1:0]  region  = va_reg[31:30];
   wire [20:0] idx     = va_reg[29:9];
   wire [20:0] pt_idx  = ptva_reg[29:9];
   wire        is_sys  = region[1];
   wire        is_ctl  = ~region[1] & region[0];
   // system half is one table; index bit 30 set is past any length
   wire        sys_bad = region[0] |
                         ({11'h000, idx} >= sys_len_reg);
   wire        prg_bad = {11'h000, idx} >= prog_len_reg;
   // control region grows downward: low indices do not exist
   wire        ctl_bad = {11'h000, idx} < ctl_len_reg;
   wire        len_bad = is_sys ? sys_bad :
                         (is_ctl ? ctl_bad : prg_bad);
   wire        pt_bad  = ~ptva_reg[31] | ptva_reg[30] |
                         ({11'h000, pt_idx} >= sys_len_reg);
   wire [31:0] pt_base = is_ctl ? ctl_base_reg : prog_base_reg;
   wire [31:0] ptva    = pt_base + {9'h000, idx, 2'h0};
   wire [29:0] sys_pme = sys_base_reg[29:0] +
                         {7'h00, idx, 2'h0};
   wire [29:0] pt_pme  = sys_base_reg[29:0] +
                         {7'h00, pt_idx, 2'h0};

   wire [22:0] look_key = (state_reg == S_SYSLOOK) ?
                          {`VATU_SYS_REGION, pt_idx} : {region, idx};
   wire        tlb_hit;
   wire [31:0] tlb_pme;
   // fill still in flight counts as a hit, saves a second fetch
   wire        fill_fwd = fill_en_reg && (fill_key_reg == look_key);
   wire        sys_hit  = tlb_hit | fill_fwd;
   wire [31:0] sys_ent  = fill_fwd ? fill_pme_reg : tlb_pme;
   wire [1:0]  chunk_size;
   wire [3:0]  chunk_bytes = 4'h1 << chunk_size;

   wire [3:0]  prot  = pme_reg[`VATU_PME_PROT_HI:`VATU_PME_PROT_LO];
   wire [1:0]  rlim  = (prot[1:0] > prot[3:2]) ? prot[1:0] : prot[3:2];
   // code zero grants no mode at all; write needs its own limit
   wire        prot_ok = (prot != 4'h0) &&
                         (wr_reg ? (mode_reg <= prot[3:2]) :
                                   (mode_reg <= rlim));
   wire        need_mod = wr_reg & ~tlb_pme[`VATU_PME_MOD];
   wire [29:0] phys = {pme_reg[`VATU_PME_FRAME_HI:0],
                       va_reg[`VATU_OFS_BITS-1:0]};

   vatu_tlb #(
      .ENTRIES (TLB_ENTRIES),
      .PTR_W   (TLB_PTR_W)
   ) u_tlb (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .look_key (look_key),
      .hit      (tlb_hit),
      .hit_pme  (tlb_pme),
      .fill_en  (fill_en_reg),
      .fill_key (fill_key_reg),
      .fill_pme (fill_pme_reg),
      .flush    (flush_reg)
   );

   vatu_chunk u_chunk (
      .addr_lo (va_reg[2:0]),
      .remain  (rem_reg),
      .size    (chunk_size)
   );

   // ****************************************************************
   // ahb-lite slave, zero wait states
   // ****************************************************************
   wire        ahb_take = hsel & hready & htrans[1];
   wire [7:0]  ofs      = haddr[7:0];
   reg  [31:0] rd_mux;

   always @* begin
      if (ofs == `VATU_SYS_BASE_OFS) begin
         rd_mux = sys_base_reg;
      end else if (ofs == `VATU_SYS_LEN_OFS) begin
         rd_mux = sys_len_reg;
      end else if (ofs == `VATU_PROG_BASE_OFS) begin
         rd_mux = prog_base_reg;
      end else if (ofs == `VATU_PROG_LEN_OFS) begin
         rd_mux = prog_len_reg;
      end else if (ofs == `VATU_CTL_BASE_OFS) begin
         rd_mux = ctl_base_reg;
      end else if (ofs == `VATU_CTL_LEN_OFS) begin
         rd_mux = ctl_len_reg;
      end else if (ofs == `VATU_STATUS_OFS) begin
         rd_mux = {29'h0000_0000, state_reg != S_IDLE, last_fault_reg};
      end else if (ofs == `VATU_FAULT_VA_OFS) begin
         rd_mux = fault_va_reg;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         hrdata        <= 32'h0000_0000;
         wr_pend_reg   <= 1'b0;
         wr_ofs_reg    <= 8'h00;
         flush_reg     <= 1'b0;
         sys_base_reg  <= `VATU_REG_RESET;
         sys_len_reg   <= `VATU_REG_RESET;
         prog_base_reg <= `VATU_REG_RESET;
         prog_len_reg  <= `VATU_REG_RESET;
         ctl_base_reg  <= `VATU_REG_RESET;
         ctl_len_reg   <= `VATU_REG_RESET;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= ahb_take & hwrite;
         wr_ofs_reg  <= ofs;
         flush_reg   <= 1'b0;
         if (ahb_take && !hwrite) begin
            hrdata <= rd_mux;
         end
         if (wr_pend_reg) begin
            if (wr_ofs_reg == `VATU_CTRL_OFS) begin
               flush_reg <= hwdata[0];
            end else if (wr_ofs_reg == `VATU_SYS_BASE_OFS) begin
               sys_base_reg <= hwdata;
            end else if (wr_ofs_reg == `VATU_SYS_LEN_OFS) begin
               sys_len_reg <= hwdata;
            end else if (wr_ofs_reg == `VATU_PROG_BASE_OFS) begin
               prog_base_reg <= hwdata;
            end else if (wr_ofs_reg == `VATU_PROG_LEN_OFS) begin
               prog_len_reg <= hwdata;
            end else if (wr_ofs_reg == `VATU_CTL_BASE_OFS) begin
               ctl_base_reg <= hwdata;
            end else if (wr_ofs_reg == `VATU_CTL_LEN_OFS) begin
               ctl_len_reg <= hwdata;
            end
         end
      end
   end

   // ****************************************************************
   // translation sequencer
   // ****************************************************************
   task fault;
      input [1:0] code;
      begin
         cpu_fault      <= 1'b1;
         cpu_fault_code <= code;
         last_fault_reg <= code;
         fault_va_reg   <= va_reg;
         cpu_ready      <= 1'b1;
         state_reg      <= S_IDLE;
      end
   endtask

   task mem_go;
      input [29:0] addr;
      input [1:0]  size;
      input        wr;
      input        tbl;
      begin
         mem_req   <= 1'b1;
         mem_addr  <= addr;
         mem_size  <= size;
         mem_write <= wr;
         mem_table <= tbl;
      end
   endtask

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg      <= S_IDLE;
         va_reg         <= 32'h0000_0000;
         rem_reg        <= 4'h0;
         wr_reg         <= 1'b0;
         mode_reg       <= 2'h0;
         pme_reg        <= 32'h0000_0000;
         pme_addr_reg   <= 30'h0000_0000;
         ptva_reg       <= 32'h0000_0000;
         fill_en_reg    <= 1'b0;
         fill_key_reg   <= 23'h00_0000;
         fill_pme_reg   <= 32'h0000_0000;
         cpu_ready      <= 1'b1;
         cpu_done       <= 1'b0;
         cpu_fault      <= 1'b0;
         cpu_fault_code <= `VATU_FLT_NONE;
         last_fault_reg <= `VATU_FLT_NONE;
         fault_va_reg   <= 32'h0000_0000;
         mem_req        <= 1'b0;
         mem_addr       <= 30'h0000_0000;
         mem_size       <= `VATU_SZ_BYTE;
         mem_write      <= 1'b0;
         mem_table      <= 1'b0;
         mem_wdata      <= 32'h0000_0000;
      end else begin
         cpu_done    <= 1'b0;
         cpu_fault   <= 1'b0;
         fill_en_reg <= 1'b0;
         if (mem_ack) begin
            mem_req <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               if (cpu_req) begin
                  va_reg    <= cpu_vaddr;
                  // zero length means an eight-byte operand
                  rem_reg   <= (cpu_len == 4'h0 || cpu_len > 4'h8) ?
                               4'h8 : cpu_len;
                  wr_reg    <= cpu_write;
                  mode_reg  <= cpu_mode;
                  cpu_ready <= 1'b0;
                  state_reg <= S_LOOK;
               end
            end
            S_LOOK: begin
               if (len_bad) begin
                  fault(`VATU_FLT_ACCV);
               end else if (tlb_hit && !need_mod) begin
                  pme_reg   <= tlb_pme;
                  state_reg <= S_CHECK;
               end else if (is_sys) begin
                  // a write to a clean page walks for the entry address
                  pme_addr_reg <= sys_pme;
                  mem_go(sys_pme, 2'h2, 1'b0, 1'b1);
                  state_reg    <= S_FPME;
               end else begin
                  ptva_reg  <= ptva;
                  state_reg <= S_SYSLOOK;
               end
            end
            S_SYSLOOK: begin
               if (pt_bad) begin
                  fault(`VATU_FLT_ACCV);
               end else if (sys_hit) begin
                  if (!sys_ent[`VATU_PME_VALID]) begin
                     fault(`VATU_FLT_TNV);
                  end else begin
                     pme_addr_reg <= {sys_ent[20:0], ptva_reg[8:0]};
                     mem_go({sys_ent[20:0], ptva_reg[8:0]},
                            2'h2, 1'b0, 1'b1);
                     state_reg <= S_FPME;
                  end
               end else begin
                  mem_go(pt_pme, 2'h2, 1'b0, 1'b1);
                  state_reg <= S_FSYS;
               end
            end
            S_FSYS: begin
               if (mem_ack) begin
                  fill_en_reg  <= 1'b1;
                  fill_key_reg <= {`VATU_SYS_REGION, pt_idx};
                  fill_pme_reg <= mem_rdata;
                  if (!mem_rdata[`VATU_PME_VALID]) begin
                     fault(`VATU_FLT_TNV);
                  end else begin
                     pme_addr_reg <= {mem_rdata[20:0], ptva_reg[8:0]};
                     state_reg    <= S_SYSLOOK;
                  end
               end
            end
            S_FPME: begin
               if (mem_ack) begin
                  pme_reg      <= mem_rdata;
                  fill_en_reg  <= 1'b1;
                  fill_key_reg <= {region, idx};
                  fill_pme_reg <= mem_rdata;
                  state_reg    <= S_CHECK;
               end
            end
            S_CHECK: begin
               // same check whether the frame is memory or device space
               if (!prot_ok) begin
                  fault(`VATU_FLT_ACCV);
               end else if (!pme_reg[`VATU_PME_VALID]) begin
                  fault(`VATU_FLT_TNV);
               end else if (wr_reg && !pme_reg[`VATU_PME_MOD]) begin
                  pme_reg[`VATU_PME_MOD] <= 1'b1;
                  fill_en_reg  <= 1'b1;
                  fill_key_reg <= {region, idx};
                  fill_pme_reg <= pme_reg | (32'h1 << `VATU_PME_MOD);
                  mem_wdata    <= pme_reg | (32'h1 << `VATU_PME_MOD);
                  mem_go(pme_addr_reg, 2'h2, 1'b1, 1'b1);
                  state_reg    <= S_MODW;
               end else begin
                  mem_go(phys, chunk_size, wr_reg, 1'b0);
                  state_reg <= S_DATA;
               end
            end
            S_MODW: begin
               if (mem_ack) begin
                  state_reg <= S_CHECK;
               end
            end
            S_DATA: begin
               if (mem_ack) begin
                  // pieces never span pages, each is translated anew
                  va_reg  <= va_reg + {28'h000_0000, chunk_bytes};
                  rem_reg <= rem_reg - chunk_bytes;
                  if (rem_reg == chunk_bytes) begin
                     cpu_done  <= 1'b1;
                     cpu_ready <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     state_reg <= S_LOOK;
                  end
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule // vatu_top

//--- tb/vatu_monitor.sv
`timescale 1ns/100ps
module vatu_monitor (
   // clock and reset
   input wire        hclk,
   input wire        hresetn,
   // processor side
   input wire        cpu_req,
   input wire        cpu_ready,
   input wire        cpu_done,
   input wire        cpu_fault,
   input wire [1:0]  cpu_fault_code,
   // memory side
   input wire        mem_req,
   input wire [29:0] mem_addr,
   input wire [1:0]  mem_size,
   input wire        mem_table,
   input wire        mem_ack
);
   // *****
   // port relations
   // *****
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_take_req: assert property (cpu_req && cpu_ready |=> !cpu_ready)
      else $error("request not taken");
   chk_hold_req: assert property (mem_req && !mem_ack |=> mem_req
      && $stable(mem_addr) && $stable(mem_size)) else $error("req moved");
   chk_word_align: assert property (mem_req && mem_size == 2'h1
      |-> !mem_addr[0]) else $error("odd word");
   chk_long_align: assert property (mem_req && mem_size[1]
      |-> mem_addr[1:0] == 2'h0) else $error("unaligned long");
   chk_quad_align: assert property (mem_req && mem_size == 2'h3
      |-> !mem_addr[2]) else $error("unaligned quad");
   chk_table_size: assert property (mem_req && mem_table
      |-> mem_size == 2'h2) else $error("entry not a long");
   chk_fault_code: assert property (cpu_fault
      |-> cpu_fault_code != 2'h0 && !cpu_done) else $error("bad fault");
   chk_done_ack: assert property (cpu_done |-> $past(mem_ack))
      else $error("done without ack");
   chk_idle_quiet: assert property (cpu_ready |-> !mem_req)
      else $error("idle access");
endmodule // vatu_monitor

//--- tb/vatu_mem_model.sv
`timescale 1ns/100ps
module vatu_mem_model (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // request side
   input  wire        mem_req,
   input  wire [29:0] mem_addr,
   input  wire [1:0]  mem_size,
   input  wire        mem_write,
   input  wire        mem_table,
   input  wire [31:0] mem_wdata,
   input  wire        slow,
   // answer side
   output reg         mem_ack,
   output reg  [31:0] mem_rdata
);
   reg [31:0] mem [0:127];
   reg [1:0]  wait_cnt;
   reg [5:0]  size_log;
   reg [29:0] last_addr;
   integer    n_table;
   integer    i;
   // *****
   // ack two cycles after request, four when slow
   // *****
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'b0;
         wait_cnt <= 2'h0;
         n_table <= 0;
      end else if (mem_req && !mem_ack && wait_cnt == {slow, 1'b1}) begin
         mem_ack <= 1'b1;
         wait_cnt <= 2'h0;
         mem_rdata <= mem[mem_addr[8:2]];
         if (mem_table && mem_write)
            mem[mem_addr[8:2]] <= mem_wdata;
         if (mem_table)
            n_table <= n_table + 1;
         else begin
            size_log <= {size_log[3:0], mem_size};
            last_addr <= mem_addr;
         end
      end else begin
         mem_ack <= 1'b0;
         // stale data must not look valid
         mem_rdata <= ~mem_rdata;
         wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
   initial begin
      mem_rdata = 32'h0;
      for (i = 0; i < 128; i = i + 1)
         mem[i] = 32'h0;
      mem[0] = 32'hf800_0009;
      mem[64] = 32'hfc00_0005;
      mem[65] = 32'h7800_0006;
      mem[66] = 32'h8800_0007;
      mem[67] = 32'hf800_0008;
   end
endmodule // vatu_mem_model

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "vatu_map.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
   num_errors = num_errors + 1; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   // *****
   // wiring
   // *****
   reg         hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, slow = 1'b0;
   reg         cpu_req = 1'b0, cpu_write = 1'b0;
   reg  [31:0] haddr = 32'h0, hwdata = 32'h0, cpu_vaddr = 32'h0, rd;
   reg  [1:0]  htrans = 2'h0, cpu_mode = 2'h0;
   reg  [3:0]  cpu_len = 4'h1;
   wire        hreadyout, hresp, cpu_ready, cpu_done, cpu_fault;
   wire        mem_req, mem_write, mem_table, mem_ack;
   wire [1:0]  cpu_fault_code, mem_size;
   wire [29:0] mem_addr;
   wire [31:0] hrdata, mem_wdata, mem_rdata;
   integer     num_errors = 0, checks = 0, n0;
   always #50 hclk = ~hclk;
   vatu_top i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cpu_req(cpu_req), .cpu_vaddr(cpu_vaddr),
      .cpu_len(cpu_len), .cpu_write(cpu_write), .cpu_mode(cpu_mode),
      .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_fault(cpu_fault),
      .cpu_fault_code(cpu_fault_code), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_write(mem_write),
      .mem_table(mem_table), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   vatu_mem_model i_mem (
      .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_write(mem_write),
      .mem_table(mem_table), .mem_wdata(mem_wdata), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // *****
   // helpers
   // *****
   task end_of_test;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task tick_rdy;
      integer n;
      for (n = 0; n < 50; n = n + 1) begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            return;
      end
      num_errors = num_errors + 1;
      end_of_test;
   endtask
   task ahb(input w, input [7:0] a, input [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      tick_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      tick_rdy;
      rd = hrdata;
   endtask
   task run(input [31:0] va, input [3:0] ln, input w, input [1:0] md,
            input [1:0] code);
      integer n;
      @(posedge hclk);
      cpu_vaddr <= va;
      cpu_len <= ln;
      cpu_write <= w;
      cpu_mode <= md;
      cpu_req <= 1'b1;
      @(posedge hclk);
      cpu_req <= 1'b0;
      // memory may stall, so the wait is long but bounded
      for (n = 0; n < 300; n = n + 1) begin
         @(posedge hclk);
         #1;
         if (cpu_done === 1'b1 || cpu_fault === 1'b1)
            break;
      end
      if (n == 300) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
      `CHK(cpu_fault, code != 2'h0)
      if (code != 2'h0)
         `CHK(cpu_fault_code, code)
   endtask
   // *****
   // scenarios
   // *****
   task t_regs;
      ahb(1'b0, `VATU_SYS_BASE_OFS, 32'h0);
      `CHK(rd, `VATU_REG_RESET)
      ahb(1'b1, `VATU_SYS_BASE_OFS, 32'h100);
      ahb(1'b1, `VATU_SYS_LEN_OFS, 32'h4);
      ahb(1'b1, `VATU_PROG_BASE_OFS, 32'h8000_0000);
      ahb(1'b1, `VATU_PROG_LEN_OFS, 32'h2);
      ahb(1'b1, `VATU_CTL_LEN_OFS, 32'h4);
      ahb(1'b0, `VATU_SYS_LEN_OFS, 32'h0);
      `CHK(rd, 32'h4)
      $display("end regs");
   endtask
   task t_sys;
      run(32'h8000_0003, 4'h1, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.n_table, 1)
      `CHK(i_mem.last_addr, 30'ha03)
      run(32'h8000_0010, 4'h4, 1'b0, 2'h3, 2'h0);
      `CHK(i_mem.n_table, 1)
      `CHK(i_mem.size_log[1:0], 2'h2)
      $display("end sys");
   endtask
   task t_split;
      @(posedge hclk);
      slow <= 1'b1;
      run(32'h8000_0001, 4'h4, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.size_log, 6'h04)
      `CHK(i_mem.last_addr, 30'ha04)
      run(32'h8000_0008, 4'h8, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.size_log[1:0], 2'h3)
      `CHK(i_mem.last_addr, 30'ha08)
      $display("end split");
   endtask
   task t_faults;
      run(32'h8000_0800, 4'h1, 1'b0, 2'h0, 2'h1);
      run(32'h8000_0200, 4'h1, 1'b0, 2'h0, 2'h2);
      run(32'h8000_0400, 4'h1, 1'b0, 2'h2, 2'h1);
      run(32'h8000_0400, 4'h1, 1'b0, 2'h1, 2'h0);
      run(32'hc000_0000, 4'h1, 1'b0, 2'h0, 2'h1);
      run(32'h8000_0600, 4'h4, 1'b1, 2'h0, 2'h0);
      `CHK(i_mem.mem[67][26], 1'b1)
      `CHK(i_mem.last_addr, 30'h1000)
      $display("end faults");
   endtask
   task t_proc;
      n0 = i_mem.n_table;
      run(32'h0000_0004, 4'h1, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.n_table, n0 + 1)
      `CHK(i_mem.last_addr, 30'h1204)
      run(32'h0000_0400, 4'h1, 1'b0, 2'h0, 2'h1);
      run(32'h4000_0000, 4'h1, 1'b0, 2'h0, 2'h1);
      ahb(1'b0, `VATU_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_0001)
      ahb(1'b0, `VATU_FAULT_VA_OFS, 32'h0);
      `CHK(rd, 32'h4000_0000)
      ahb(1'b1, `VATU_CTRL_OFS, 32'h0000_0001);
      n0 = i_mem.n_table;
      run(32'h0000_0004, 4'h1, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.n_table, n0 + 2)
      `CHK(i_mem.last_addr, 30'h1204)
      run(32'h8000_0003, 4'h1, 1'b0, 2'h0, 2'h0);
      `CHK(i_mem.n_table, n0 + 2)
      $display("end proc");
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_sys;
      t_split;
      t_faults;
      t_proc;
      end_of_test;
   end
endmodule // testbench
bind vatu_top vatu_monitor i_mon (
   .hclk(hclk), .hresetn(hresetn), .cpu_req(cpu_req),
   .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_fault(cpu_fault),
   .cpu_fault_code(cpu_fault_code), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_size(mem_size), .mem_table(mem_table),
   .mem_ack(mem_ack));
